// File: verilog/fbe_pkg.sv
// constants, register map and types of the flash block-erase sequencer
package fbe_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_INDEX = 8'h04;
    localparam logic [7:0] ADDR_PROT = 8'h08;
    localparam logic [7:0] ADDR_PARAM = 8'h0C;
    localparam logic [7:0] ADDR_TIMING = 8'h10;
    localparam int STAT_COMMAND_COMPLETE_FLAG = 7;
    localparam int STAT_ACCESS_ERROR_FLAG = 5;
    localparam int STAT_PROTECTION_VIOLATION_FLAG = 4;
    localparam int STAT_VERR = 1;
    localparam int STAT_VFATAL = 0;
    localparam int PROT_OPEN = 7;
    localparam int PROT_RNV = 6;
    localparam int PROT_HDIS = 5;
    localparam int PROT_HS_LSB = 3;
    localparam int PROT_LDIS = 2;
    localparam int PROT_LS_LSB = 0;
    localparam logic [15:0] CMD_BLOCK_ERASE = 16'h0009;
    localparam logic [2:0] IDX_LAST = 3'h1;
    localparam logic [1:0] PF_BLOCK_SEL = 2'h3;
    localparam logic [1:0] DF_BLOCK_SEL = 2'h0;
    localparam logic [7:0] PROT_RST = 8'h7F;
    localparam logic [7:0] PROT_FAULT = 8'h7F;
    // allowed scenario moves, bit [from*8+to], scenario = {open, hdis, ldis}
    localparam logic [63:0] SCN_ALLOWED = 64'hFF5A3C18080C0A0F;
    localparam logic [15:0] ERASE_CYC_RST = 16'h0400;
    localparam logic [15:0] VERIFY_CYC_RST = 16'h0100;
    localparam logic [1:0] LOAD_CYC = 2'h3;
    typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_CHECK, ST_ERASE, ST_VERIFY} fbe_state_t;
endpackage

// File: verilog/fbe_busy_timer.sv
// down counter that models a multi-cycle array operation
`timescale 1ns/1ps
module fbe_busy_timer
    import fbe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [15:0] cycles,
    output logic busy,
    output logic done
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (start)
            // zero would never finish, so it counts as one
            nxt_cnt = (cycles == 16'h0000) ? 16'h0001 : cycles;
        else if (cnt_ff != 16'h0000)
            nxt_cnt = cnt_ff - 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            cnt_ff <= 16'h0000;
        else
            cnt_ff <= nxt_cnt;
    end

    assign busy = (cnt_ff != 16'h0000);
    assign done = (cnt_ff == 16'h0001);
endmodule

// File: verilog/fbe_prot_dec.sv
// decoder and write filter for the program-flash protection register
`timescale 1ns/1ps
module fbe_prot_dec
    import fbe_pkg::*;
(
    input wire logic [7:0] cur,
    input wire logic [7:0] wdata,
    output logic any_prot,
    output logic accept,
    output logic [7:0] merged
);
    logic [2:0] cur_scn;
    logic [2:0] new_scn;

    always_comb
    begin
        merged = cur;
        merged[PROT_OPEN] = wdata[PROT_OPEN];
        merged[PROT_HDIS] = wdata[PROT_HDIS];
        merged[PROT_LDIS] = wdata[PROT_LDIS];
        // sizes only move while their range is disabled
        if (cur[PROT_HDIS])
            merged[PROT_HS_LSB +: 2] = wdata[PROT_HS_LSB +: 2];
        if (cur[PROT_LDIS])
            merged[PROT_LS_LSB +: 2] = wdata[PROT_LS_LSB +: 2];
        cur_scn = {cur[PROT_OPEN], cur[PROT_HDIS], cur[PROT_LDIS]};
        new_scn = {merged[PROT_OPEN], merged[PROT_HDIS], merged[PROT_LDIS]};
        accept = SCN_ALLOWED[{cur_scn, new_scn}];
        // open with both ranges off is the only unprotected case
        any_prot = (cur_scn != 3'h7);
    end
endmodule

// File: verilog/fbe_top.sv
// flash block-erase sequencer with protection register and apb slave
`timescale 1ns/1ps
module fbe_top
    import fbe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_permitted,
    input wire logic [7:0] nvm_prot_byte,
    input wire logic nvm_prot_fault,
    input wire logic verify_err,
    input wire logic verify_fatal,
    output logic erase_active,
    output logic erase_dflash,
    output logic [17:0] erase_addr,
    output logic verify_active
);
    // pins from the array side pass two flops first
    logic [11:0] sync1_ff;
    logic [11:0] sync2_ff;
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sync1_ff <= 12'h000;
            sync2_ff <= 12'h000;
        end
        else
        begin
            sync1_ff <= {cmd_permitted, nvm_prot_fault, verify_err, verify_fatal, nvm_prot_byte};
            sync2_ff <= sync1_ff;
        end
    end
    logic s_permit;
    logic s_fault;
    logic s_verr;
    logic s_vfatal;
    logic [7:0] s_byte;
    assign {s_permit, s_fault, s_verr, s_vfatal, s_byte} = sync2_ff;

    fbe_state_t state_ff, nxt_state;
    logic command_complete_flag_ff, nxt_command_complete_flag;
    logic access_error_flag_ff, nxt_access_error_flag;
    logic protection_violation_flag_ff, nxt_protection_violation_flag;
    logic verr_ff, nxt_verr;
    logic vfatal_ff, nxt_vfatal;
    logic [2:0] index_ff, nxt_index;
    logic [15:0] word0_ff, nxt_word0;
    logic [15:0] word1_ff, nxt_word1;
    logic [7:0] prot_ff, nxt_prot;
    logic [15:0] erase_cyc_ff, nxt_erase_cyc;
    logic [15:0] verify_cyc_ff, nxt_verify_cyc;
    logic [1:0] load_cnt_ff, nxt_load_cnt;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic erase_act_ff, nxt_erase_act;
    logic erase_df_ff, nxt_erase_df;
    logic [17:0] erase_addr_ff, nxt_erase_addr;
    logic verify_act_ff, nxt_verify_act;

    logic any_prot;
    logic prot_accept;
    logic [7:0] prot_merged;
    fbe_prot_dec u_dec (
        .cur(prot_ff),
        .wdata(pwdata[7:0]),
        .any_prot(any_prot),
        .accept(prot_accept),
        .merged(prot_merged)
    );

    logic tmr_start;
    logic [15:0] tmr_cycles;
    logic tmr_busy;
    logic tmr_done;
    fbe_busy_timer u_tmr (
        .clock(clock),
        .rst_b(rst_b),
        .start(tmr_start),
        .cycles(tmr_cycles),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    logic setup;
    logic wr;
    logic mapped;
    logic launch;
    logic [17:0] gaddr;
    logic is_pf;
    logic is_df;
    logic bad_addr;
    logic unaligned;
    assign setup = psel && !penable;
    assign wr = psel && penable && pready_ff && pwrite && command_complete_flag_ff;
    assign mapped = (paddr == ADDR_STATUS) || (paddr == ADDR_INDEX) || (paddr == ADDR_PROT)
        || (paddr == ADDR_PARAM) || (paddr == ADDR_TIMING);
    // new launch refused while an access error or protection violation is still flagged
    assign launch = wr && (paddr == ADDR_STATUS) && pwdata[STAT_COMMAND_COMPLETE_FLAG] && !access_error_flag_ff
        && !protection_violation_flag_ff;
    assign gaddr = {word0_ff[1:0], word1_ff};
    assign is_pf = (gaddr[17:16] == PF_BLOCK_SEL);
    assign is_df = (gaddr[17:16] == DF_BLOCK_SEL);
    assign bad_addr = !is_pf && !is_df;
    assign unaligned = (is_pf && (gaddr[2:0] != 3'h0)) || (is_df && gaddr[0]);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_command_complete_flag = command_complete_flag_ff;
        nxt_access_error_flag = access_error_flag_ff;
        nxt_protection_violation_flag = protection_violation_flag_ff;
        nxt_verr = verr_ff;
        nxt_vfatal = vfatal_ff;
        nxt_prot = prot_ff;
        nxt_load_cnt = load_cnt_ff;
        nxt_erase_act = erase_act_ff;
        nxt_erase_df = erase_df_ff;
        nxt_erase_addr = erase_addr_ff;
        nxt_verify_act = verify_act_ff;
        tmr_start = 1'b0;
        tmr_cycles = erase_cyc_ff;
        // flag clears by software; hardware sets below override them
        if (wr && (paddr == ADDR_STATUS))
        begin
            if (pwdata[STAT_ACCESS_ERROR_FLAG])
                nxt_access_error_flag = 1'b0;
            if (pwdata[STAT_PROTECTION_VIOLATION_FLAG])
                nxt_protection_violation_flag = 1'b0;
        end
        if (wr && (paddr == ADDR_PROT) && prot_accept)
            nxt_prot = prot_merged;
        case (state_ff)
            ST_LOAD:
            begin
                // wait until the stored byte has crossed the synchroniser
                nxt_load_cnt = load_cnt_ff + 2'h1;
                if (load_cnt_ff == LOAD_CYC)
                begin
                    nxt_prot = s_fault ? PROT_FAULT : s_byte;
                    nxt_command_complete_flag = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (launch)
                begin
                    nxt_command_complete_flag = 1'b0;
                    nxt_verr = 1'b0;
                    nxt_vfatal = 1'b0;
                    nxt_state = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                if ((index_ff != IDX_LAST) || !s_permit || bad_addr || unaligned
                    || (word0_ff[15:8] != CMD_BLOCK_ERASE[7:0]))
                begin
                    nxt_access_error_flag = 1'b1;
                    nxt_command_complete_flag = 1'b1;
                    nxt_state = ST_IDLE;
                end
                else if (is_pf && any_prot)
                begin
                    nxt_protection_violation_flag = 1'b1;
                    nxt_command_complete_flag = 1'b1;
                    nxt_state = ST_IDLE;
                end
                else
                begin
                    tmr_start = 1'b1;
                    nxt_erase_act = 1'b1;
                    nxt_erase_df = is_df;
                    nxt_erase_addr = gaddr;
                    nxt_state = ST_ERASE;
                end
            end
            ST_ERASE:
            begin
                if (tmr_done)
                begin
                    tmr_start = 1'b1;
                    tmr_cycles = verify_cyc_ff;
                    nxt_erase_act = 1'b0;
                    nxt_verify_act = 1'b1;
                    nxt_state = ST_VERIFY;
                end
            end
            ST_VERIFY:
            begin
                if (tmr_done)
                begin
                    nxt_verr = s_verr || s_vfatal;
                    nxt_vfatal = s_vfatal;
                    nxt_verify_act = 1'b0;
                    nxt_command_complete_flag = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default:
                nxt_state = ST_LOAD;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state_ff <= ST_LOAD;
            command_complete_flag_ff <= 1'b0;
            access_error_flag_ff <= 1'b0;
            protection_violation_flag_ff <= 1'b0;
            verr_ff <= 1'b0;
            vfatal_ff <= 1'b0;
            prot_ff <= PROT_RST;
            load_cnt_ff <= 2'h0;
            erase_act_ff <= 1'b0;
            erase_df_ff <= 1'b0;
            erase_addr_ff <= 18'h00000;
            verify_act_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            command_complete_flag_ff <= nxt_command_complete_flag;
            access_error_flag_ff <= nxt_access_error_flag;
            protection_violation_flag_ff <= nxt_protection_violation_flag;
            verr_ff <= nxt_verr;
            vfatal_ff <= nxt_vfatal;
            prot_ff <= nxt_prot;
            load_cnt_ff <= nxt_load_cnt;
            erase_act_ff <= nxt_erase_act;
            erase_df_ff <= nxt_erase_df;
            erase_addr_ff <= nxt_erase_addr;
            verify_act_ff <= nxt_verify_act;
        end
    end

    // apb: read data registered in setup, one-cycle access phase
    always_comb
    begin
        nxt_index = index_ff;
        nxt_word0 = word0_ff;
        nxt_word1 = word1_ff;
        nxt_erase_cyc = erase_cyc_ff;
        nxt_verify_cyc = verify_cyc_ff;
        nxt_pready = setup;
        nxt_pslverr = setup && !mapped;
        nxt_prdata = 32'h0000_0000;
        if (wr && (paddr == ADDR_INDEX))
            nxt_index = pwdata[2:0];
        if (wr && (paddr == ADDR_PARAM) && (index_ff == 3'h0))
            nxt_word0 = pwdata[15:0];
        if (wr && (paddr == ADDR_PARAM) && (index_ff == IDX_LAST))
            nxt_word1 = pwdata[15:0];
        if (wr && (paddr == ADDR_TIMING))
        begin
            nxt_erase_cyc = pwdata[15:0];
            nxt_verify_cyc = pwdata[31:16];
        end
        if (setup && !pwrite)
        begin
            case (paddr)
                ADDR_STATUS:
                begin
                    nxt_prdata[STAT_COMMAND_COMPLETE_FLAG] = command_complete_flag_ff;
                    nxt_prdata[STAT_ACCESS_ERROR_FLAG] = access_error_flag_ff;
                    nxt_prdata[STAT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_ff;
                    nxt_prdata[STAT_VERR] = verr_ff;
                    nxt_prdata[STAT_VFATAL] = vfatal_ff;
                end
                ADDR_INDEX: nxt_prdata[2:0] = index_ff;
                ADDR_PROT: nxt_prdata[7:0] = prot_ff;
                ADDR_PARAM:
                    nxt_prdata[15:0] = (index_ff == 3'h0) ? word0_ff
                        : ((index_ff == IDX_LAST) ? word1_ff : 16'h0000);
                ADDR_TIMING: nxt_prdata = {verify_cyc_ff, erase_cyc_ff};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            index_ff <= 3'h0;
            word0_ff <= 16'h0000;
            word1_ff <= 16'h0000;
            erase_cyc_ff <= ERASE_CYC_RST;
            verify_cyc_ff <= VERIFY_CYC_RST;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            index_ff <= nxt_index;
            word0_ff <= nxt_word0;
            word1_ff <= nxt_word1;
            erase_cyc_ff <= nxt_erase_cyc;
            verify_cyc_ff <= nxt_verify_cyc;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign erase_active = erase_act_ff;
    assign erase_dflash = erase_df_ff;
    assign erase_addr = erase_addr_ff;
    assign verify_active = verify_act_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_launch_clears_command_complete_flag: assert property (state_ff == ST_IDLE && launch |=> !command_complete_flag_ff)
        else $error("launch did not clear complete flag");
    a_busy_command_complete_flag_low: assert property (erase_act_ff || verify_act_ff |-> !command_complete_flag_ff)
        else $error("complete flag high during operation");
    a_index_refused: assert property (state_ff == ST_CHECK && index_ff != IDX_LAST
        |=> access_error_flag_ff && command_complete_flag_ff && !erase_act_ff)
        else $error("bad index not refused");
    a_mode_refused: assert property (state_ff == ST_CHECK && !s_permit
        |=> access_error_flag_ff && !erase_act_ff)
        else $error("command in wrong mode not refused");
    a_block_check: assert property (state_ff == ST_CHECK && (bad_addr || unaligned)
        |=> access_error_flag_ff)
        else $error("bad block or alignment not flagged");
    a_prot_viol: assert property (state_ff == ST_CHECK && !access_error_flag_ff && is_pf && any_prot
        && index_ff == IDX_LAST && s_permit && !unaligned
        && word0_ff[15:8] == CMD_BLOCK_ERASE[7:0] |=> protection_violation_flag_ff && !erase_act_ff)
        else $error("protected block erase not refused");
    a_prot_ignored: assert property (wr && paddr == ADDR_PROT && !prot_accept
        && state_ff == ST_IDLE |=> $stable(prot_ff))
        else $error("disallowed protection write took effect");
    a_size_locked: assert property (wr && paddr == ADDR_PROT && !prot_ff[PROT_HDIS]
        |=> prot_ff[PROT_HS_LSB +: 2] == $past(prot_ff[PROT_HS_LSB +: 2]))
        else $error("high size changed while range enabled");
    a_fault_load: assert property (state_ff == ST_LOAD && load_cnt_ff == LOAD_CYC && s_fault
        |=> prot_ff == PROT_FAULT)
        else $error("fault load did not fully protect");
    a_erase_then_verify: assert property ($fell(erase_act_ff) && state_ff == ST_VERIFY
        |-> verify_act_ff && !command_complete_flag_ff)
        else $error("erase not followed by verify");
    a_apb_answer: assert property (setup |=> pready_ff)
        else $error("apb access phase not answered");

    c_erase_done: cover property ($fell(verify_act_ff) ##0 command_complete_flag_ff);
    c_access_err: cover property ($rose(access_error_flag_ff));
    c_prot_viol: cover property ($rose(protection_violation_flag_ff));
    c_prot_write: cover property (wr && paddr == ADDR_PROT && prot_accept);
endmodule

// File: tb/fbe_flash_model.sv
// behavioural model of the program and data flash arrays behind the sequencer
`timescale 1ns/1ps
module fbe_flash_model
    import fbe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic erase_active,
    input wire logic erase_dflash,
    input wire logic [17:0] erase_addr,
    input wire logic verify_active,
    input wire logic [7:0] cfg_byte,
    input wire logic cfg_fault,
    input wire logic cfg_err,
    input wire logic cfg_fatal,
    output logic [7:0] nvm_prot_byte,
    output logic nvm_prot_fault,
    output logic verify_err,
    output logic verify_fatal,
    output int erase_count,
    output int erase_cycles,
    output int verify_cycles,
    output logic [17:0] last_addr,
    output logic last_dflash
);
    logic erase_prev;
    logic verify_prev;

    // configuration field holds the stored byte; fault flag marks a bad phrase read
    assign nvm_prot_byte = cfg_byte;
    assign nvm_prot_fault = cfg_fault;
    // result only valid during verify; inverted outside so stale sampling shows up
    assign verify_err = verify_active ? cfg_err : ~cfg_err;
    assign verify_fatal = verify_active ? cfg_fatal : ~cfg_fatal;

    initial
    begin
        erase_count = 0;
        erase_cycles = 0;
        verify_cycles = 0;
        last_addr = 18'h00000;
        last_dflash = 1'b0;
        erase_prev = 1'b0;
        verify_prev = 1'b0;
    end

    // records which block was wiped and how long each array phase lasted
    always @(posedge clock)
    begin
        if (erase_active && !erase_prev)
        begin
            erase_count <= erase_count + 1;
            last_addr <= erase_addr;
            last_dflash <= erase_dflash;
        end
        if (erase_active)
            erase_cycles <= erase_prev ? erase_cycles + 1 : 1;
        if (verify_active)
            verify_cycles <= verify_prev ? verify_cycles + 1 : 1;
        erase_prev <= erase_active;
        verify_prev <= verify_active;
    end
endmodule

// File: tb/flash_block_erase_and_protection_test.sv
// self-checking bench for the flash block-erase sequencer over apb
`timescale 1ns/1ps
module flash_block_erase_and_protection_test
    import fbe_pkg::*;
;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_val;
    logic rd_err, cmd_permitted, nvm_prot_fault, verify_err, verify_fatal;
    logic [7:0] nvm_prot_byte;
    logic erase_active, erase_dflash, verify_active, last_dflash;
    logic [17:0] erase_addr, last_addr;
    logic cfg_fault, cfg_err, cfg_fatal;
    int erase_count, erase_cycles, verify_cycles;
    int err_total, total_checks;

    fbe_top dut_u (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_permitted(cmd_permitted), .nvm_prot_byte(nvm_prot_byte),
        .nvm_prot_fault(nvm_prot_fault), .verify_err(verify_err),
        .verify_fatal(verify_fatal), .erase_active(erase_active),
        .erase_dflash(erase_dflash), .erase_addr(erase_addr), .verify_active(verify_active));

    fbe_flash_model mem_u (.clock(clock), .rst_b(rst_b), .erase_active(erase_active),
        .erase_dflash(erase_dflash), .erase_addr(erase_addr), .verify_active(verify_active),
        .cfg_byte(8'hFF), .cfg_fault(cfg_fault), .cfg_err(cfg_err), .cfg_fatal(cfg_fatal),
        .nvm_prot_byte(nvm_prot_byte), .nvm_prot_fault(nvm_prot_fault),
        .verify_err(verify_err), .verify_fatal(verify_fatal), .erase_count(erase_count),
        .erase_cycles(erase_cycles), .verify_cycles(verify_cycles), .last_addr(last_addr),
        .last_dflash(last_dflash));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd_val, exp);
    endtask

    // no register writes while a command runs, so only reads until complete
    task automatic poll_done();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h00000000);
            n++;
        end
        while (rd_val[STAT_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 300);
    endtask

    task automatic cmd(input logic [1:0] sel, input logic [15:0] lo, input logic [2:0] ix,
        input logic [7:0] exp, input int n_er);
        int n0;
        n0 = erase_count;
        apb(1'b1, ADDR_INDEX, 32'h00000000);
        apb(1'b1, ADDR_PARAM, {16'h0000, 8'h09, 6'h00, sel});
        apb(1'b1, ADDR_INDEX, 32'h00000001);
        apb(1'b1, ADDR_PARAM, {16'h0000, lo});
        apb(1'b1, ADDR_INDEX, {29'h00000000, ix});
        apb(1'b1, ADDR_STATUS, 32'h00000080);
        apb(1'b0, ADDR_STATUS, 32'h00000000);
        if (n_er > 0)
            check({31'h0, rd_val[STAT_COMMAND_COMPLETE_FLAG]}, 32'h00000000);
        poll_done();
        check(rd_val, {24'h000000, exp});
        check(erase_count - n0, n_er);
        apb(1'b1, ADDR_STATUS, 32'h00000030);
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        poll_done();
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        finish_test();
    end

    initial
    begin
        err_total = 0;
        total_checks = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        cmd_permitted = 1'b1;
        cfg_fault = 1'b0;
        cfg_err = 1'b0;
        cfg_fatal = 1'b0;
        do_reset();
        rdchk(ADDR_PROT, 32'h000000FF);
        rdchk(ADDR_TIMING, 32'h01000400);
        apb(1'b0, 8'h20, 32'h00000000);
        check({rd_err, rd_val[30:0]}, 32'h80000000);
        apb(1'b1, ADDR_TIMING, 32'h00040008);
        cmd(PF_BLOCK_SEL, 16'h0000, 3'h1, 8'h80, 1);
        check({last_dflash, last_addr}, 19'h30000);
        check(erase_cycles, 8);
        check(verify_cycles, 4);
        cfg_err <= 1'b1;
        cfg_fatal <= 1'b1;
        cmd(DF_BLOCK_SEL, 16'h0002, 3'h1, 8'h83, 1);
        check({last_dflash, last_addr}, 19'h40002);
        cfg_fatal <= 1'b0;
        cmd(DF_BLOCK_SEL, 16'h0004, 3'h1, 8'h82, 1);
        cfg_err <= 1'b0;
        cmd(DF_BLOCK_SEL, 16'h0002, 3'h0, 8'hA0, 0);
        cmd_permitted <= 1'b0;
        cmd(PF_BLOCK_SEL, 16'h0000, 3'h1, 8'hA0, 0);
        cmd_permitted <= 1'b1;
        cmd(2'h1, 16'h0000, 3'h1, 8'hA0, 0);
        cmd(2'h2, 16'h0000, 3'h1, 8'hA0, 0);
        cmd(PF_BLOCK_SEL, 16'h0004, 3'h1, 8'hA0, 0);
        cmd(DF_BLOCK_SEL, 16'h0001, 3'h1, 8'hA0, 0);
        apb(1'b1, ADDR_PROT, 32'h000000FB);
        rdchk(ADDR_PROT, 32'h000000FB);
        cmd(PF_BLOCK_SEL, 16'h0000, 3'h1, 8'h90, 0);
        cmd(DF_BLOCK_SEL, 16'h0002, 3'h1, 8'h80, 1);
        apb(1'b1, ADDR_PROT, 32'h000000FF);
        rdchk(ADDR_PROT, 32'h000000FB);
        apb(1'b1, ADDR_PROT, 32'h000000F3);
        rdchk(ADDR_PROT, 32'h000000F3);
        apb(1'b1, ADDR_PROT, 32'h000000D3);
        rdchk(ADDR_PROT, 32'h000000D3);
        apb(1'b1, ADDR_PROT, 32'h000000CB);
        rdchk(ADDR_PROT, 32'h000000D3);
        apb(1'b1, ADDR_PROT, 32'h00000093);
        rdchk(ADDR_PROT, 32'h000000D3);
        cfg_fault <= 1'b1;
        do_reset();
        rdchk(ADDR_PROT, {24'h000000, PROT_FAULT});
        cmd(PF_BLOCK_SEL, 16'h0000, 3'h1, 8'h90, 0);
        finish_test();
    end
endmodule
